/* File: core/d2t_pkg.sv */
package d2t_pkg;

    // ==================================================
    // Register map
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_MODE = 8'h08;
    localparam logic [7:0] OFF_ERR = 8'h0C;

    localparam int CTRL_AL_LSB = 0;
    localparam int CTRL_AL_W = 3;
    localparam logic [2:0] RST_CTRL_AL = 3'h0;

    localparam int ST_CKE = 0;
    localparam int ST_ODT = 1;
    localparam int ST_DQS_DIFF = 2;
    localparam int ST_READ_OK = 3;
    localparam int ST_PD_ACTIVE = 4;
    localparam int ST_SLOW_EXIT = 5;
    localparam int ST_PD_PRECH = 6;

    localparam int ERR_CKE = 0;
    localparam int ERR_XARD = 1;
    localparam int ERR_WTR = 2;
    localparam int ERR_W = 3;

    // ==================================================
    // Mode register layout
    localparam int MR_W = 14;
    localparam int MR_DQS_N_BIT = 10;
    localparam int MR_PD_SLOW_BIT = 12;
    localparam int AP_BIT = 10;
    localparam logic [13:0] RST_MR = 14'h0000;

    // ==================================================
    // Timing in input clock edges; AOFD_HALF_NCK counts half edges
    localparam int CKE_REG_NCK = 3;
    localparam int XARD_NCK = 2;
    localparam int XARDS_BASE_NCK = 8;
    localparam int AOND_NCK = 2;
    localparam int AOFD_HALF_NCK = 5;
    localparam int AOFD_NCK = (AOFD_HALF_NCK + 1) / 2;
    localparam int WTR_NCK = 2;

    // ==================================================
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        CMD_NOP, CMD_DESEL, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS
    } d2t_cmd_t;

    typedef enum logic [1:0] {
        PD_UP, PD_ACTIVE, PD_PRECH, PD_EXIT
    } d2t_pd_t;

    function automatic logic reg_hit(input logic [7:0] addr);
        reg_hit = (addr == OFF_CTRL) || (addr == OFF_STATUS) || (addr == OFF_MODE) || (addr == OFF_ERR);
    endfunction

    function automatic d2t_cmd_t decode_cmd(input logic [3:0] c);
        unique case (c)
            4'h0: decode_cmd = CMD_MRS;
            4'h1: decode_cmd = CMD_REF;
            4'h2: decode_cmd = CMD_PRE;
            4'h3: decode_cmd = CMD_ACT;
            4'h4: decode_cmd = CMD_WR;
            4'h5: decode_cmd = CMD_RD;
            4'h7: decode_cmd = CMD_NOP;
            default: decode_cmd = c[3] ? CMD_DESEL : CMD_NOP;
        endcase
    endfunction

endpackage

/* File: core/d2t_reg_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface d2t_reg_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;

    modport bus (output wr_en, output wr_addr, output wr_data, output wr_strb, output rd_addr, input rd_data);
    modport regs (input wr_en, input wr_addr, input wr_data, input wr_strb, input rd_addr, output rd_data);
endinterface
`default_nettype wire

/* File: core/d2t_axil_slave.sv */
`timescale 1ns/1ps
`default_nettype none
module d2t_axil_slave
    import d2t_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    d2t_reg_if.bus rb
);
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic bvalid_q, bvalid_d, awready_q, awready_d, wready_q, wready_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic do_wr;

    // ==================================================
    // Write channel: address and data taken in either order
    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        do_wr = aw_have_q && w_have_q && !bvalid_q;
        if (awvalid && awready_q) begin
            aw_have_d = 1'b1;
            awaddr_d = awaddr;
        end
        if (wvalid && wready_q) begin
            w_have_d = 1'b1;
            wdata_d = wdata;
            wstrb_d = wstrb;
        end
        if (do_wr) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = reg_hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
    end

    // ==================================================
    // Read channel: one cycle from address to data
    always_comb begin
        arready_d = arready_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (arvalid && arready_q) begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rdata_d = reg_hit(araddr) ? rb.rd_data : 32'h0000_0000;
            rresp_d = reg_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
            arready_q <= 1'b1;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else begin
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign rb.wr_en = do_wr && reg_hit(awaddr_q);
    assign rb.wr_addr = awaddr_q;
    assign rb.wr_data = wdata_q;
    assign rb.wr_strb = wstrb_q;
    assign rb.rd_addr = araddr;
    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
endmodule
`default_nettype wire

/* File: core/d2t_timing.sv */
// What this block does
// - CKE counts only after three equal samples; controller holds it that long.
// - Device tolerates long write postamble; the limit only costs bus turnaround.
// - Mode bit 10 low selects differential data strobes for write capture.
// - Mode bit 12 picks fast or slow active power-down exit before reads.
// - Termination turns on two clock edges after ODT first registers high.
// - Termination turns off three clock edges after ODT first registers low, 2.5 rounded up.
// - Nanosecond parameters work at rounded-up clock counts when jitter limits hold.
// - Clock-count units mean real clock edges, not elapsed time.
`timescale 1ns/1ps
`default_nettype none
module d2t_timing
    import d2t_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    input wire logic cke_pin,
    input wire logic cs_n_pin,
    input wire logic ras_n_pin,
    input wire logic cas_n_pin,
    input wire logic we_n_pin,
    input wire logic [2:0] ba_pin,
    input wire logic [13:0] addr_pin,
    input wire logic odt_pin,
    output logic cke_level_q,
    output logic odt_term_en_q,
    output logic dqs_diff_en_q,
    output logic read_ok_q
);
    localparam int PIN_W = 23;

    d2t_reg_if rif ();

    d2t_axil_slave u_bus (
        .clk(clk), .rst(rst),
        .awaddr(s_awaddr), .awvalid(s_awvalid), .awready(s_awready),
        .wdata(s_wdata), .wstrb(s_wstrb), .wvalid(s_wvalid), .wready(s_wready),
        .bresp(s_bresp), .bvalid(s_bvalid), .bready(s_bready),
        .araddr(s_araddr), .arvalid(s_arvalid), .arready(s_arready),
        .rdata(s_rdata), .rresp(s_rresp), .rvalid(s_rvalid), .rready(s_rready),
        .rb(rif.bus)
    );

    // ==================================================
    // Pin synchroniser
    logic [PIN_W-1:0] sync1_q, sync2_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            // Command strobes idle high, CKE low, so no false level change after reset
            sync1_q <= 23'h00000F;
            sync2_q <= 23'h00000F;
        end else begin
            sync1_q <= {odt_pin, addr_pin, ba_pin, cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin};
            sync2_q <= sync1_q;
        end
    end

    logic [3:0] cmd_bits;
    logic cke_s, odt_s;
    logic [2:0] ba_s;
    logic [13:0] addr_s;
    d2t_cmd_t cmd;
    assign cmd_bits = sync2_q[3:0];
    assign cke_s = sync2_q[4];
    assign ba_s = sync2_q[7:5];
    assign addr_s = sync2_q[21:8];
    assign odt_s = sync2_q[22];
    // Commands count only while CKE stands registered high
    assign cmd = cke_level_q ? decode_cmd(cmd_bits) : CMD_NOP;

    // ==================================================
    // State
    logic cke_cand_q, cke_cand_d, cke_level_d;
    logic [1:0] cke_cnt_q, cke_cnt_d;
    logic [7:0] bank_open_q, bank_open_d;
    logic [MR_W-1:0] mr_q, mr_d;
    logic [2:0] al_q, al_d;
    d2t_pd_t pd_q, pd_d;
    logic [3:0] exit_cnt_q, exit_cnt_d, xards_cyc;
    logic odt_prev_q, odt_prev_d, odt_tgt_q, odt_tgt_d, odt_term_en_d;
    logic [1:0] odt_cnt_q, odt_cnt_d;
    logic [1:0] wtr_cnt_q, wtr_cnt_d;
    logic [ERR_W-1:0] err_q, err_d, err_set, err_clr;
    logic dqs_diff_en_d, read_ok_d;

    // Slow exit shortens with additive latency, never below one edge
    assign xards_cyc = (al_q >= 3'(XARDS_BASE_NCK - 1)) ? 4'h1 : 4'(XARDS_BASE_NCK) - {1'b0, al_q};

    always_comb begin
        err_set = '0;
        // ==================================================
        // CKE registration by consecutive samples
        cke_cand_d = cke_s;
        cke_level_d = cke_level_q;
        cke_cnt_d = cke_cnt_q;
        if (cke_s != cke_cand_q) begin
            cke_cnt_d = 2'h1;
            // Level changed before the previous one was registered
            if (cke_cand_q != cke_level_q) begin
                err_set[ERR_CKE] = 1'b1;
            end
        end else if (cke_cnt_q != 2'(CKE_REG_NCK)) begin
            cke_cnt_d = cke_cnt_q + 2'h1;
        end
        if (cke_cnt_d == 2'(CKE_REG_NCK)) begin
            cke_level_d = cke_s;
        end

        // ==================================================
        // Bank tracking and mode register load
        bank_open_d = bank_open_q;
        mr_d = mr_q;
        unique case (cmd)
            CMD_ACT: bank_open_d[ba_s] = 1'b1;
            CMD_PRE: begin
                if (addr_s[AP_BIT]) begin
                    bank_open_d = 8'h00;
                end else begin
                    bank_open_d[ba_s] = 1'b0;
                end
            end
            CMD_MRS: begin
                if (ba_s == 3'h0) begin
                    mr_d = addr_s;
                end
            end
            default: begin
            end
        endcase
        dqs_diff_en_d = !mr_q[MR_DQS_N_BIT];

        // ==================================================
        // Power-down entry and exit, counted in edges
        pd_d = pd_q;
        exit_cnt_d = exit_cnt_q;
        unique case (pd_q)
            PD_UP: begin
                if (cke_level_q && !cke_level_d) begin
                    pd_d = (|bank_open_q) ? PD_ACTIVE : PD_PRECH;
                end
            end
            PD_ACTIVE: begin
                if (cke_level_d) begin
                    pd_d = PD_EXIT;
                    exit_cnt_d = mr_q[MR_PD_SLOW_BIT] ? xards_cyc : 4'(XARD_NCK);
                end
            end
            PD_PRECH: begin
                if (cke_level_d) begin
                    pd_d = PD_UP;
                end
            end
            PD_EXIT: begin
                if (cmd == CMD_RD) begin
                    err_set[ERR_XARD] = 1'b1;
                end
                if (exit_cnt_q == 4'h1) begin
                    pd_d = PD_UP;
                end
                exit_cnt_d = exit_cnt_q - 4'h1;
            end
        endcase
        read_ok_d = (pd_d == PD_UP);

        // ==================================================
        // On-die termination delays; off rounds 2.5 edges up to 3
        odt_prev_d = odt_s;
        odt_tgt_d = odt_tgt_q;
        odt_cnt_d = odt_cnt_q;
        odt_term_en_d = odt_term_en_q;
        if (odt_s && !odt_prev_q) begin
            odt_tgt_d = 1'b1;
            odt_cnt_d = 2'(AOND_NCK);
        end else if (!odt_s && odt_prev_q) begin
            odt_tgt_d = 1'b0;
            odt_cnt_d = 2'(AOFD_NCK);
        end else if (odt_cnt_q != 2'h0) begin
            odt_cnt_d = odt_cnt_q - 2'h1;
            if (odt_cnt_q == 2'h1) begin
                odt_term_en_d = odt_tgt_q;
            end
        end

        // ==================================================
        // Write-to-read turnaround watch; postamble length is never checked
        wtr_cnt_d = (wtr_cnt_q != 2'h0) ? wtr_cnt_q - 2'h1 : 2'h0;
        if (cmd == CMD_WR) begin
            wtr_cnt_d = 2'(WTR_NCK - 1);
        end else if (cmd == CMD_RD && wtr_cnt_q != 2'h0) begin
            err_set[ERR_WTR] = 1'b1;
        end
    end

    // ==================================================
    // Registers: CTRL steers exit timing, ERR clears on write of one
    always_comb begin
        al_d = al_q;
        err_clr = '0;
        if (rif.wr_en && rif.wr_strb[0]) begin
            if (rif.wr_addr == OFF_CTRL) begin
                al_d = rif.wr_data[CTRL_AL_LSB +: CTRL_AL_W];
            end
            if (rif.wr_addr == OFF_ERR) begin
                err_clr = rif.wr_data[ERR_W-1:0];
            end
        end
        // A new event beats a simultaneous clear
        err_d = (err_q & ~err_clr) | err_set;
    end

    always_comb begin
        rif.rd_data = 32'h0000_0000;
        unique case (rif.rd_addr)
            OFF_CTRL: rif.rd_data[CTRL_AL_LSB +: CTRL_AL_W] = al_q;
            OFF_STATUS: begin
                rif.rd_data[ST_CKE] = cke_level_q;
                rif.rd_data[ST_ODT] = odt_term_en_q;
                rif.rd_data[ST_DQS_DIFF] = dqs_diff_en_q;
                rif.rd_data[ST_READ_OK] = read_ok_q;
                rif.rd_data[ST_PD_ACTIVE] = (pd_q == PD_ACTIVE);
                rif.rd_data[ST_SLOW_EXIT] = mr_q[MR_PD_SLOW_BIT];
                rif.rd_data[ST_PD_PRECH] = (pd_q == PD_PRECH);
            end
            OFF_MODE: rif.rd_data[MR_W-1:0] = mr_q;
            OFF_ERR: rif.rd_data[ERR_W-1:0] = err_q;
            default: rif.rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cke_cand_q <= 1'b0;
            cke_cnt_q <= 2'h0;
            cke_level_q <= 1'b0;
            bank_open_q <= 8'h00;
            mr_q <= RST_MR;
            al_q <= RST_CTRL_AL;
            pd_q <= PD_UP;
            exit_cnt_q <= 4'h0;
            odt_prev_q <= 1'b0;
            odt_tgt_q <= 1'b0;
            odt_cnt_q <= 2'h0;
            odt_term_en_q <= 1'b0;
            wtr_cnt_q <= 2'h0;
            err_q <= '0;
            dqs_diff_en_q <= 1'b1;
            read_ok_q <= 1'b1;
        end else begin
            cke_cand_q <= cke_cand_d;
            cke_cnt_q <= cke_cnt_d;
            cke_level_q <= cke_level_d;
            bank_open_q <= bank_open_d;
            mr_q <= mr_d;
            al_q <= al_d;
            pd_q <= pd_d;
            exit_cnt_q <= exit_cnt_d;
            odt_prev_q <= odt_prev_d;
            odt_tgt_q <= odt_tgt_d;
            odt_cnt_q <= odt_cnt_d;
            odt_term_en_q <= odt_term_en_d;
            wtr_cnt_q <= wtr_cnt_d;
            err_q <= err_d;
            dqs_diff_en_q <= dqs_diff_en_d;
            read_ok_q <= read_ok_d;
        end
    end
endmodule
`default_nettype wire

/* File: sim/d2t_timing_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module d2t_timing_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] s_bresp,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    input wire logic cke_pin,
    input wire logic odt_pin,
    input wire logic cke_level_q,
    input wire logic odt_term_en_q,
    input wire logic read_ok_q
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // ====
    // Pin timing
    property p_cke_wait;
        $rose(cke_pin) && !cke_level_q |-> !cke_level_q [*3];
    endproperty
    a_cke_wait: assert property (p_cke_wait) else $error("cke early");
    property p_cke_reg;
        $rose(cke_pin) ##0 cke_pin [*6] |-> cke_level_q;
    endproperty
    a_cke_reg: assert property (p_cke_reg) else $error("cke late");
    property p_odt_wait;
        $rose(odt_pin) && !odt_term_en_q |-> !odt_term_en_q [*4];
    endproperty
    a_odt_wait: assert property (p_odt_wait) else $error("odt on early");
    property p_odt_on;
        $rose(odt_pin) ##0 odt_pin [*6] |-> odt_term_en_q;
    endproperty
    a_odt_on: assert property (p_odt_on) else $error("odt on late");
    // Turn-off is one clock later than turn-on, so never earlier
    property p_odt_hold;
        $fell(odt_pin) && odt_term_en_q |-> odt_term_en_q [*4];
    endproperty
    a_odt_hold: assert property (p_odt_hold) else $error("odt off early");
    property p_odt_off;
        $fell(odt_pin) ##0 !odt_pin [*7] |-> !odt_term_en_q;
    endproperty
    a_odt_off: assert property (p_odt_off) else $error("odt off late");
    property p_exit;
        $rose(cke_level_q) |-> ##[1:8] read_ok_q;
    endproperty
    a_exit: assert property (p_exit) else $error("exit too long");
    // ====
    // Register bus
    property p_b_hold;
        s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
    property p_r_resp;
        s_arvalid && s_arready |=> s_rvalid;
    endproperty
    a_r_resp: assert property (p_r_resp) else $error("no rvalid");
endmodule
bind d2t_timing d2t_timing_chk u_chk (.clk, .rst, .s_bresp, .s_bvalid, .s_bready, .s_arvalid, .s_arready,
    .s_rvalid, .cke_pin, .odt_pin, .cke_level_q, .odt_term_en_q, .read_ok_q);
`default_nettype wire

/* File: sim/d2t_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module d2t_ctrl_model (
    input wire logic clk,
    output logic cke_pin = 1'b0,
    output logic cs_n_pin = 1'b1,
    output logic ras_n_pin = 1'b1,
    output logic cas_n_pin = 1'b1,
    output logic we_n_pin = 1'b1,
    output logic [2:0] ba_pin = 3'h0,
    output logic [13:0] addr_pin = 14'h0000,
    output logic odt_pin = 1'b0
);
    // ====
    // Caller holds each level past its registration time, except t_cke's one-clock CKE low glitch
    task automatic set_cke(input logic v);
        @(posedge clk);
        cke_pin <= v;
    endtask
    task automatic set_odt(input logic v);
        @(posedge clk);
        odt_pin <= v;
    endtask
    // Callers space commands by whole idle clocks, except t_wtr's back-to-back write and read; no refresh or data is modelled
    task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
        @(posedge clk);
        cs_n_pin <= c[3];
        ras_n_pin <= c[2];
        cas_n_pin <= c[1];
        we_n_pin <= c[0];
        ba_pin <= b;
        addr_pin <= a;
    endtask
    // Released bus flips, so a stale value is never mistaken for a command
    task automatic idle();
        @(posedge clk);
        cs_n_pin <= 1'b1;
        ras_n_pin <= 1'b1;
        cas_n_pin <= 1'b1;
        we_n_pin <= 1'b1;
        ba_pin <= ~ba_pin;
        addr_pin <= ~addr_pin;
    endtask
endmodule
`default_nettype wire

/* File: sim/test_d2t_timing.sv */
`timescale 1ns/1ps
`default_nettype none
module test_d2t_timing;
    import d2t_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0;
    logic [3:0] s_wstrb = 4'hF;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp;
    logic [31:0] s_rdata;
    logic cke_pin, cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin, odt_pin;
    logic [2:0] ba_pin;
    logic [13:0] addr_pin;
    logic cke_level_q, odt_term_en_q, dqs_diff_en_q, read_ok_q;
    int checks = 0;
    int n_mismatch = 0;
    always #2.5 clk = ~clk;
    d2t_timing u_dut (.clk, .rst, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
        .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata,
        .s_rresp, .s_rvalid, .s_rready, .cke_pin, .cs_n_pin, .ras_n_pin, .cas_n_pin, .we_n_pin,
        .ba_pin, .addr_pin, .odt_pin, .cke_level_q, .odt_term_en_q, .dqs_diff_en_q, .read_ok_q);
    d2t_ctrl_model u_ctrl (.clk, .cke_pin, .cs_n_pin, .ras_n_pin, .cas_n_pin, .we_n_pin, .ba_pin,
        .addr_pin, .odt_pin);
    // ====
    // Shared helpers
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic expired();
        chk(32'h0, 32'h1);
        complete_run();
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        @(posedge clk);
        s_awaddr <= a;
        s_awvalid <= 1'b1;
        s_wdata <= d;
        s_wvalid <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (s_bvalid && s_bready) break;
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
            // Bready rises once both channels are accepted, so the response does not wait
            if (!s_awvalid && !s_wvalid) s_bready <= 1'b1;
        end
        if (i == 40) expired();
        s_bready <= 1'b0;
        chk({30'h0, s_bresp}, {30'h0, er});
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int i;
        @(posedge clk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        for (i = 0; i < 40; i++) begin
            @(posedge clk);
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
            if (s_rvalid) break;
        end
        if (i == 40) expired();
        s_rready <= 1'b0;
        chk(s_rdata, ed);
        chk({30'h0, s_rresp}, {30'h0, er});
    endtask
    task automatic count_to(ref logic s, input logic v, output int n);
        n = 0;
        while (s !== v && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 40) expired();
    endtask
    // ====
    // Scenarios
    task automatic t_reset();
        axr(OFF_STATUS, 32'h0000000C, RESP_OKAY);
        axr(OFF_ERR, 32'h0, RESP_OKAY);
        axw(OFF_CTRL, 32'h5, RESP_OKAY);
        axr(OFF_CTRL, 32'h5, RESP_OKAY);
        axw(OFF_STATUS, 32'hFF, RESP_OKAY);
        axr(OFF_STATUS, 32'h0000000C, RESP_OKAY);
        axw(8'h10, 32'h1, RESP_SLVERR);
        axr(8'h10, 32'h0, RESP_SLVERR);
        axw(OFF_CTRL, 32'h0, RESP_OKAY);
        // Lane 0 disabled: the write must leave CTRL alone
        s_wstrb <= 4'hE;
        axw(OFF_CTRL, 32'h7, RESP_OKAY);
        s_wstrb <= 4'hF;
        axr(OFF_CTRL, 32'h0, RESP_OKAY);
        $display("done reset");
    endtask
    task automatic t_cke();
        int n;
        u_ctrl.set_cke(1'b1);
        count_to(cke_level_q, 1'b1, n);
        chk(n, CKE_REG_NCK + 2);
        u_ctrl.set_cke(1'b0);
        u_ctrl.set_cke(1'b1);
        repeat (6) @(posedge clk);
        chk({31'h0, cke_level_q}, 32'h1);
        axr(OFF_ERR, 32'h1, RESP_OKAY);
        axw(OFF_ERR, 32'h1, RESP_OKAY);
        axr(OFF_ERR, 32'h0, RESP_OKAY);
        $display("done cke");
    endtask
    task automatic t_mrs();
        u_ctrl.cmd(4'h0, 3'h0, 14'h0400);
        u_ctrl.idle();
        u_ctrl.cmd(4'h0, 3'h1, 14'h0000);
        u_ctrl.idle();
        repeat (6) @(posedge clk);
        chk({31'h0, dqs_diff_en_q}, 32'h0);
        axr(OFF_MODE, 32'h0400, RESP_OKAY);
        u_ctrl.cmd(4'h0, 3'h0, 14'h1000);
        u_ctrl.idle();
        repeat (6) @(posedge clk);
        chk({31'h0, dqs_diff_en_q}, 32'h1);
        axr(OFF_STATUS, 32'h0000002D, RESP_OKAY);
        $display("done mode");
    endtask
    task automatic t_odt();
        int n;
        u_ctrl.set_odt(1'b1);
        count_to(odt_term_en_q, 1'b1, n);
        chk(n, 5);
        repeat (4) @(posedge clk);
        u_ctrl.set_odt(1'b0);
        count_to(odt_term_en_q, 1'b0, n);
        chk(n, 6);
        $display("done odt");
    endtask
    task automatic t_pd(input logic [13:0] mr, input logic [31:0] al, input int exp_n, input logic rd_early);
        int n;
        axw(OFF_CTRL, al, RESP_OKAY);
        u_ctrl.cmd(4'h0, 3'h0, mr);
        u_ctrl.idle();
        u_ctrl.cmd(4'h3, 3'h2, 14'h0010);
        u_ctrl.idle();
        u_ctrl.set_cke(1'b0);
        count_to(read_ok_q, 1'b0, n);
        axr(OFF_STATUS, {26'h0, mr[12], 5'h14}, RESP_OKAY);
        u_ctrl.set_cke(1'b1);
        count_to(cke_level_q, 1'b1, n);
        if (rd_early) begin
            u_ctrl.cmd(4'h5, 3'h2, 14'h0000);
            u_ctrl.idle();
            repeat (8) @(posedge clk);
            axr(OFF_ERR, 32'h2, RESP_OKAY);
            axw(OFF_ERR, 32'h2, RESP_OKAY);
        end else begin
            count_to(read_ok_q, 1'b1, n);
            chk(n, exp_n);
        end
        $display("done power-down");
    endtask
    task automatic t_wtr();
        u_ctrl.cmd(4'h4, 3'h1, 14'h0000);
        u_ctrl.cmd(4'h5, 3'h1, 14'h0000);
        u_ctrl.idle();
        repeat (6) @(posedge clk);
        axr(OFF_ERR, 32'h4, RESP_OKAY);
        axw(OFF_ERR, 32'h4, RESP_OKAY);
        u_ctrl.cmd(4'h4, 3'h1, 14'h0000);
        u_ctrl.idle();
        u_ctrl.cmd(4'h5, 3'h1, 14'h0000);
        u_ctrl.idle();
        repeat (6) @(posedge clk);
        axr(OFF_ERR, 32'h0, RESP_OKAY);
        $display("done turnaround");
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_cke();
        t_mrs();
        t_odt();
        t_pd(14'h0000, 32'h0, XARD_NCK, 1'b0);
        t_pd(14'h1000, 32'h3, XARDS_BASE_NCK - 3, 1'b0);
        t_pd(14'h1000, 32'h0, 0, 1'b1);
        t_wtr();
        complete_run();
    end
endmodule
`default_nettype wire
